// file: core/pdc_powerdown_pin_ctrl.sv
// power-down, port float, step/hold and external strobe control
// assumes core requests are synchronous to clk_sys and held for a machine cycle
`timescale 1ns/10ps
`default_nettype none

module pdc_powerdown_pin_ctrl
  import pdc_pkg::*;
#(
  parameter int MC_LEN = MC_LEN_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins in
  input wire logic int_n,
  input wire logic standby_pin,
  input wire logic external_fetch_select,
  input wire logic step_hold_n,
  // core requests for the current machine cycle
  input wire logic fetch_req,
  input wire logic [11:0] fetch_addr,
  input wire logic dmem_rd_req,
  input wire logic dmem_wr_req,
  input wire logic [7:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  input wire logic exp_req,
  input wire logic t0_out_req,
  input wire logic t0_out_val,
  // core status
  output logic cpu_clk_en,
  output logic osc_run,
  output logic int_req,
  output logic wake_int_pulse,
  output logic wake_resume_pulse,
  output logic [11:0] wake_vector,
  // strobes
  output logic ale,
  output logic ale_oe_n,
  output logic expander_strobe_fetch_strobe_n,
  output logic expander_strobe_fetch_strobe_oe_n,
  output logic rd_n,
  output logic wr_n,
  output logic expander_strobe,
  output logic ctl_strobe_oe_n,
  output logic t0_out,
  output logic t0_oe_n,
  // ports
  output logic [7:0] bus_port_out,
  output logic bus_port_oe_n,
  output logic [7:0] port_one_out,
  output logic [7:0] port_one_oe_n,
  output logic [7:0] port_one_accel,
  output logic [7:0] port_two_out,
  output logic [7:0] port_two_oe_n,
  output logic [7:0] port_two_accel,
  // step/hold pin pulls
  output logic ss_pulldown_en,
  output logic ss_pullup_en
);

  pdc_power_type state_ff, nxt_state;
  pdc_float_type float_ff;
  logic ack_ff, ie_ff, wr_fire, cmd_fire, running, mc_last, ale_rise, in_ale, in_stb;
  logic [3:0] phase_ff;
  logic [7:0] bus_data_ff, bus_pin_latch_ff, port_one_ff, port_two_ff;
  logic [7:0] p1_prev_ff, p2_prev_ff, cmd_op;
  logic cyc_fetch_ff, cyc_rd_ff, cyc_wr_ff, cyc_exp_ff;
  logic wake_pend_ff, in_addr;
  logic [1:0] wake_cnt_ff;
  logic fl_ports, fl_all, ext_keep;

  // register bus: one wait cycle, then answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_fire = avs_write & ack_ff & avs_byteenable[0];
  assign cmd_op = avs_writedata[7:0];
  assign cmd_fire = wr_fire & (avs_address == REG_CMD) & (state_ff == PS_RUN);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read & ~ack_ff) begin
      case (avs_address)
        REG_CTRL: avs_readdata <= {31'h0, ie_ff};
        REG_STATUS: avs_readdata <= {24'h0, step_hold_n, external_fetch_select, int_n,
                                     float_ff, state_ff};
        REG_BUS_DATA: avs_readdata <= {24'h0, bus_data_ff};
        REG_PORT_ONE: avs_readdata <= {24'h0, port_one_ff};
        REG_PORT_TWO: avs_readdata <= {24'h0, port_two_ff};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // interrupt enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ie_ff <= RST_IE;
    end else if (wr_fire && avs_address == REG_CTRL) begin
      ie_ff <= avs_writedata[CTRL_IE_BIT];
    end
  end

  // output data latches, separate from the address path
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_ff <= RST_BUS_DATA;
      port_one_ff <= RST_PORT;
      port_two_ff <= RST_PORT;
    end else if (wr_fire) begin
      if (avs_address == REG_BUS_DATA) bus_data_ff <= avs_writedata[7:0];
      if (avs_address == REG_PORT_ONE) port_one_ff <= avs_writedata[7:0];
      if (avs_address == REG_PORT_TWO) port_two_ff <= avs_writedata[7:0];
    end
  end

  // power state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PS_RUN: begin
        if (cmd_fire && cmd_op == OP_CLK_HALT) nxt_state = PS_CLK_HALT;
        else if (cmd_fire && cmd_op == OP_OSC_STOP) nxt_state = PS_OSC_STOP;
        else if (mc_last && !step_hold_n) nxt_state = PS_STEP_HOLD;
      end
      PS_CLK_HALT: if (!int_n) nxt_state = PS_RUN;
      PS_OSC_STOP: if (!int_n) nxt_state = step_hold_n ? PS_RUN : PS_STEP_HOLD;
      PS_STANDBY: if (standby_pin) nxt_state = step_hold_n ? PS_RUN : PS_STEP_HOLD;
      PS_STEP_HOLD: if (step_hold_n) nxt_state = PS_RUN;
      default: nxt_state = PS_RUN;
    endcase
    if (!standby_pin) nxt_state = PS_STANDBY;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= PS_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign running = (state_ff == PS_RUN);
  assign cpu_clk_en = running;
  assign osc_run = (state_ff != PS_OSC_STOP) && (state_ff != PS_STANDBY);
  assign ss_pulldown_en = ~osc_run;
  assign ss_pullup_en = osc_run;

  // float mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      float_ff <= FL_NONE;
    end else if (!int_n) begin
      float_ff <= FL_NONE;
    end else if (cmd_fire) begin
      case (cmd_op)
        OP_PORT_FLOAT: float_ff <= FL_PORT;
        OP_ALL_FLOAT: float_ff <= FL_ALL;
        OP_FLOAT_RELEASE: float_ff <= FL_NONE;
        default: float_ff <= float_ff;
      endcase
    end
  end

  // machine cycle phase, advances only while the CPU clock runs
  assign mc_last = running && (phase_ff == 4'(MC_LEN - 1));
  assign ale_rise = running && (phase_ff == 4'h0);
  assign in_ale = phase_ff < ALE_END;
  assign in_stb = (phase_ff >= STB_START) && (phase_ff < STB_END);
  // address held one clock past the latch strobe fall
  assign in_addr = phase_ff <= ALE_END;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 4'h0;
    end else if (running) begin
      phase_ff <= mc_last ? 4'h0 : phase_ff + 4'h1;
    end
  end

  // core requests captured at the start of each machine cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_fetch_ff <= 1'b0;
      cyc_rd_ff <= 1'b0;
      cyc_wr_ff <= 1'b0;
      cyc_exp_ff <= 1'b0;
    end else if (ale_rise) begin
      cyc_fetch_ff <= fetch_req & external_fetch_select;
      cyc_rd_ff <= dmem_rd_req;
      cyc_wr_ff <= dmem_wr_req & ~dmem_rd_req;
      cyc_exp_ff <= exp_req;
    end
  end

  // strobes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ale <= 1'b0;
      expander_strobe_fetch_strobe_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      expander_strobe <= 1'b1;
      t0_out <= 1'b0;
    end else begin
      ale <= running & in_ale;
      expander_strobe_fetch_strobe_n <= ~(running & cyc_fetch_ff & in_stb);
      rd_n <= ~(running & cyc_rd_ff & in_stb);
      wr_n <= ~(running & cyc_wr_ff & in_stb);
      expander_strobe <= ~(running & cyc_exp_ff & in_stb);
      t0_out <= t0_out_val;
    end
  end

  // bus port value: address from the latch strobe to one clock past its fall in fetch, read and write cycles, data otherwise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_pin_latch_ff <= RST_BUS_DATA;
    end else if (ale_rise && external_fetch_select) begin
      bus_pin_latch_ff <= bus_data_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_port_out <= RST_BUS_DATA;
      port_one_out <= RST_PORT;
      port_two_out <= RST_PORT;
    end else begin
      if (cyc_fetch_ff && in_addr) bus_port_out <= fetch_addr[7:0];
      else if ((cyc_rd_ff || cyc_wr_ff) && in_addr) bus_port_out <= dmem_addr;
      else if (cyc_wr_ff) bus_port_out <= dmem_wdata;
      else if (external_fetch_select) bus_port_out <= bus_pin_latch_ff;
      else bus_port_out <= bus_data_ff;
      port_one_out <= port_one_ff;
      if (cyc_fetch_ff) port_two_out <= {port_two_ff[7:4], fetch_addr[11:8]};
      else port_two_out <= port_two_ff;
    end
  end

  // output enables, low while driving
  assign fl_ports = (float_ff != FL_NONE) | ~osc_run & (state_ff == PS_STANDBY);
  assign fl_all = (float_ff == FL_ALL) | (state_ff == PS_STANDBY);
  assign ext_keep = external_fetch_select & (state_ff != PS_STANDBY);
  assign port_one_oe_n = {8{fl_ports}};
  assign port_two_oe_n = {{4{fl_ports}}, {4{fl_ports & ~ext_keep}}};
  assign bus_port_oe_n = (fl_ports & ~ext_keep) | ((cyc_rd_ff | cyc_fetch_ff) & in_stb);
  assign ctl_strobe_oe_n = fl_all;
  assign t0_oe_n = fl_all | ~t0_out_req;
  assign ale_oe_n = fl_all & ~ext_keep;
  assign expander_strobe_fetch_strobe_oe_n = fl_all & ~ext_keep;

  // rise accelerators per port bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      p1_prev_ff <= RST_PORT;
      p2_prev_ff <= RST_PORT;
    end else begin
      p1_prev_ff <= port_one_out;
      p2_prev_ff <= port_two_out;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_accel
      assign port_one_accel[gi] = port_one_out[gi] & ~p1_prev_ff[gi] & ~port_one_oe_n[gi];
      assign port_two_accel[gi] = port_two_out[gi] & ~p2_prev_ff[gi] & ~port_two_oe_n[gi];
    end
  endgenerate

  // interrupt request and wake sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_req <= 1'b0;
    end else begin
      int_req <= ie_ff & ~int_n & running & ~wake_pend_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_pend_ff <= 1'b0;
      wake_cnt_ff <= 2'h0;
      wake_int_pulse <= 1'b0;
      wake_resume_pulse <= 1'b0;
      wake_vector <= 12'h0;
    end else begin
      wake_int_pulse <= 1'b0;
      wake_resume_pulse <= 1'b0;
      if ((state_ff == PS_CLK_HALT || state_ff == PS_OSC_STOP) && !int_n) begin
        wake_pend_ff <= 1'b1;
        wake_cnt_ff <= 2'h0;
      end else if (wake_pend_ff && running) begin
        if (int_n) begin
          wake_pend_ff <= 1'b0;
          wake_resume_pulse <= 1'b1;
        end else if (ale_rise) begin
          if (wake_cnt_ff == INT_WAKE_ALES - 2'h1) begin
            wake_pend_ff <= 1'b0;
            wake_int_pulse <= ie_ff;
            wake_resume_pulse <= ~ie_ff;
            wake_vector <= ie_ff ? INT_VECTOR : 12'h0;
          end else begin
            wake_cnt_ff <= wake_cnt_ff + 2'h1;
          end
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // running clocks since the last latch strobe rise
  logic ale_q_ff;
  logic [4:0] ale_gap_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ale_q_ff <= 1'b0;
      ale_gap_ff <= 5'h0;
    end else begin
      ale_q_ff <= ale;
      if (!running) ale_gap_ff <= 5'h0;
      else if (ale && !ale_q_ff) ale_gap_ff <= 5'h1;
      else ale_gap_ff <= ale_gap_ff + 5'h1;
    end
  end

  sequence s_ale_pulse;
    ale [*2] ##1 !ale;
  endsequence

  property p_int_req;
    ie_ff && !int_n && running && !wake_pend_ff |=> int_req;
  endproperty
  a_int_req: assert property (p_int_req) else $error("int request missing");

  property p_ie_reset;
    $rose(rst_n) |-> !ie_ff;
  endproperty
  a_ie_reset: assert property (p_ie_reset) else $error("enable set after reset");

  property p_halt_wake;
    state_ff == PS_CLK_HALT && !int_n && standby_pin |=> state_ff == PS_RUN;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt not woken");

  property p_ale_width;
    $rose(ale) && running ##1 running |-> s_ale_pulse;
  endproperty
  a_ale_width: assert property (p_ale_width) else $error("latch strobe width");

  property p_ale_period;
    ale_gap_ff == 5'(MC_LEN) |-> $rose(ale);
  endproperty
  a_ale_period: assert property (p_ale_period) else $error("latch strobe period");

  property p_standby_entry;
    !standby_pin |=> state_ff == PS_STANDBY && !osc_run;
  endproperty
  a_standby_entry: assert property (p_standby_entry) else $error("standby missed");

  property p_standby_float;
    state_ff == PS_STANDBY |-> port_one_oe_n == 8'hff && port_two_oe_n == 8'hff
      && bus_port_oe_n && ctl_strobe_oe_n;
  endproperty
  a_standby_float: assert property (p_standby_float) else $error("standby drives");

  property p_osc_stop;
    cmd_fire && cmd_op == OP_OSC_STOP && standby_pin |=> !osc_run && !cpu_clk_en;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator still on");

  property p_clk_halt;
    state_ff == PS_CLK_HALT |-> osc_run && !cpu_clk_en;
  endproperty
  a_clk_halt: assert property (p_clk_halt) else $error("halt state clocks");

  property p_float_release;
    float_ff != FL_NONE && !int_n |=> float_ff == FL_NONE;
  endproperty
  a_float_release: assert property (p_float_release) else $error("float held");

  property p_accel;
    port_one_accel[0] |-> $rose(port_one_out[0]);
  endproperty
  a_accel: assert property (p_accel) else $error("accel without rise");

  property p_ss_pull;
    !osc_run |-> ss_pulldown_en && !ss_pullup_en;
  endproperty
  a_ss_pull: assert property (p_ss_pull) else $error("step pin pull wrong");

  property p_step_hold;
    state_ff == PS_STEP_HOLD && !step_hold_n && standby_pin |=> !cpu_clk_en;
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("cpu ran while held");

  property p_fetch_strobe;
    !expander_strobe_fetch_strobe_n |-> external_fetch_select && !ale;
  endproperty
  a_fetch_strobe: assert property (p_fetch_strobe) else $error("fetch strobe in ale");

endmodule

`default_nettype wire

// file: common/pdc_pkg.sv
// constants, encodings and states for the power-down and pin control block
// assumes one 100 MHz clock and a 32-bit Avalon-MM register slave
package pdc_pkg;
  // instruction opcodes seen on the command register
  localparam logic [7:0] OP_CLK_HALT = 8'h01;
  localparam logic [7:0] OP_OSC_STOP = 8'h82;
  localparam logic [7:0] OP_PORT_FLOAT = 8'ha2;
  localparam logic [7:0] OP_ALL_FLOAT = 8'hc2;
  localparam logic [7:0] OP_FLOAT_RELEASE = 8'h62;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BUS_DATA = 8'h0c;
  localparam logic [7:0] REG_PORT_ONE = 8'h10;
  localparam logic [7:0] REG_PORT_TWO = 8'h14;
  // field positions
  localparam int CTRL_IE_BIT = 0;
  localparam int ST_FLOAT_LSB = 3;
  localparam int ST_INT_BIT = 5;
  localparam int ST_EXT_BIT = 6;
  localparam int ST_STEP_BIT = 7;
  // reset values
  localparam logic RST_IE = 1'b0;
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [7:0] RST_BUS_DATA = 8'h00;
  // machine cycle timing in system clocks, wake delay in latch strobes, interrupt vector
  localparam int MC_LEN_DEF = 15;
  localparam logic [3:0] ALE_END = 4'h3;
  localparam logic [3:0] STB_START = 4'h6;
  localparam logic [3:0] STB_END = 4'hc;
  localparam logic [1:0] INT_WAKE_ALES = 2'h2;
  localparam logic [11:0] INT_VECTOR = 12'h003;

  typedef enum logic [2:0] {
    PS_RUN = 3'b000,
    PS_CLK_HALT = 3'b001,
    PS_OSC_STOP = 3'b010,
    PS_STANDBY = 3'b011,
    PS_STEP_HOLD = 3'b100
  } pdc_power_type;

  typedef enum logic [1:0] {
    FL_NONE = 2'b00,
    FL_PORT = 2'b01,
    FL_ALL = 2'b10
  } pdc_float_type;
endpackage

// file: dv/pdc_mem_model.sv
// external program/data memory seen from the strobe pins
// assumes addresses latch on address strobe fall and data on write strobe rise
`timescale 1ns/10ps
`default_nettype none
module pdc_mem_model (
  // strobes
  input wire logic ale,
  input wire logic expander_strobe_fetch_strobe_n,
  input wire logic wr_n,
  // buses
  input wire logic [7:0] bus_port_out,
  input wire logic [7:0] port_two_out,
  // observed
  output logic [11:0] lat_addr,
  output logic [7:0] wr_data,
  output logic [15:0] fetch_cnt
);
  initial begin
    lat_addr = 12'h000;
    wr_data = 8'h00;
    fetch_cnt = 16'h0000;
  end
  // address taken on the falling address strobe
  always @(negedge ale) lat_addr <= {port_two_out[3:0], bus_port_out};
  // data memory write captured when the write strobe ends
  always @(posedge wr_n) wr_data <= bus_port_out;
  always @(negedge expander_strobe_fetch_strobe_n) fetch_cnt <= fetch_cnt + 16'h0001;
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the power-down and pin control block
// assumes one 100 MHz clock and the package register map
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pdc_pkg::*;
  logic clk_sys, rst_n, avs_read, avs_write, int_n, standby_pin, efs, fetch_req, dmem_wr_req;
  logic ss_n;
  logic [7:0] avs_address, dmem_addr, dmem_wdata;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [11:0] fetch_addr, lat_addr;
  logic avs_waitrequest, cpu_clk_en, osc_run, int_req, ale, pfs_n, wr_n, pd_en, pu_en;
  logic [7:0] bus_out, p1_out, p1_oe_n, p1_acc, p2_out, wr_data;
  logic [15:0] fetch_cnt;
  int fails, checks, seed, i, j;
  logic [7:0] flt_ops[2] = '{OP_PORT_FLOAT, OP_ALL_FLOAT};
  logic [7:0] stop_ops[2] = '{OP_CLK_HALT, OP_OSC_STOP};

  pdc_powerdown_pin_ctrl #(.MC_LEN(MC_LEN_DEF)) u_pdc_powerdown_pin_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .int_n(int_n),
    .standby_pin(standby_pin), .external_fetch_select(efs), .step_hold_n(ss_n),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .dmem_rd_req(1'b0),
    .dmem_wr_req(dmem_wr_req), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .exp_req(1'b0), .t0_out_req(1'b0), .t0_out_val(1'b0), .cpu_clk_en(cpu_clk_en),
    .osc_run(osc_run), .int_req(int_req), .wake_int_pulse(), .wake_resume_pulse(),
    .wake_vector(), .ale(ale), .ale_oe_n(), .expander_strobe_fetch_strobe_n(pfs_n),
    .expander_strobe_fetch_strobe_oe_n(), .rd_n(), .wr_n(wr_n), .expander_strobe(),
    .ctl_strobe_oe_n(), .t0_out(), .t0_oe_n(), .bus_port_out(bus_out), .bus_port_oe_n(),
    .port_one_out(p1_out), .port_one_oe_n(p1_oe_n), .port_one_accel(p1_acc),
    .port_two_out(p2_out), .port_two_oe_n(), .port_two_accel(),
    .ss_pulldown_en(pd_en), .ss_pullup_en(pu_en));

  pdc_mem_model u_pdc_mem_model (.ale(ale), .expander_strobe_fetch_strobe_n(pfs_n), .wr_n(wr_n),
    .bus_port_out(bus_out), .port_two_out(p2_out), .lat_addr(lat_addr),
    .wr_data(wr_data), .fetch_cnt(fetch_cnt));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] exp_st(logic [2:0] st, logic [1:0] fl, logic in_n);
    return {24'h0, ss_n, efs, in_n, fl, st};
  endfunction

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    logic w;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    w = 1'b1;
    for (int k = 0; k < 50 && w; k++) begin
      @(posedge clk_sys);
      w = avs_waitrequest;
      rd = avs_readdata;
    end
    if (w) begin
      fails++;
      wrap_up();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic cycles(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic done(string s);
    $display("test %s done", s);
  endtask

  initial begin
    cycles(90000);
    fails++;
    wrap_up();
  end

  initial begin
    seed = 32'h32e7;
    {rst_n, avs_read, avs_write, int_n, standby_pin, efs, fetch_req, dmem_wr_req} = 8'h1c;
    {avs_address, dmem_addr, dmem_wdata, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    ss_n = 1'b1;
    fetch_addr = 12'h000;
    cycles(12);
    rst_n <= 1'b1;
    bus(0, REG_STATUS, 0);
    chk(rd, exp_st(3'h0, 2'h0, 1'b1));
    bus(0, REG_CTRL, 0);
    chk(rd, 32'h0);
    bus(0, REG_PORT_ONE, 0);
    chk(rd, {24'h0, RST_PORT});
    bus(0, 8'h3c, 0);
    chk(rd, 32'h0);
    done("reset");
    // external fetches at random addresses
    efs <= 1'b1;
    for (i = 0; i < 4; i++) begin
      fetch_addr <= 12'($random(seed));
      fetch_req <= 1'b1;
      j = fetch_cnt;
      for (int k = 0; k < 100 && fetch_cnt == j; k++) @(posedge clk_sys);
      chk(fetch_cnt, j + 1);
      chk(lat_addr, fetch_addr);
      fetch_req <= 1'b0;
      cycles(30);
    end
    bus(1, REG_BUS_DATA, 32'h5a);
    fetch_req <= 1'b1;
    cycles(45);
    for (int k = 0; k < 20 && pfs_n; k++) @(posedge clk_sys);
    chk(bus_out, 8'h5a);
    fetch_req <= 1'b0;
    bus(0, REG_BUS_DATA, 0);
    chk(rd, 32'h5a);
    done("fetch");
    // data memory write
    dmem_addr <= 8'($random(seed));
    dmem_wdata <= 8'($random(seed));
    dmem_wr_req <= 1'b1;
    for (int k = 0; k < 100 && wr_n; k++) @(posedge clk_sys);
    chk(lat_addr[7:0], dmem_addr);
    dmem_wr_req <= 1'b0;
    for (int k = 0; k < 100 && !wr_n; k++) @(posedge clk_sys);
    chk(wr_data, dmem_wdata);
    done("dmem");
    // every float and stop pairing, woken by the interrupt pin
    for (i = 0; i < 2; i++) begin
      for (j = 0; j < 2; j++) begin
        bus(1, REG_CMD, flt_ops[i]);
        bus(1, REG_CMD, stop_ops[j]);
        cycles(2);
        chk({pd_en, pu_en}, j ? 2'b10 : 2'b01);
        bus(0, REG_STATUS, 0);
        chk(rd, exp_st(j ? 3'h2 : 3'h1, 2'(i + 1), 1'b1));
        chk({cpu_clk_en, osc_run}, {1'b0, !j});
        chk(p1_oe_n, 8'hff);
        if (j) chk({pd_en, pu_en}, 2'b10);
        int_n <= 1'b0;
        cycles(40);
        bus(0, REG_STATUS, 0);
        chk(rd, exp_st(3'h0, 2'h0, 1'b0));
        chk({cpu_clk_en, pu_en}, 2'b11);
        int_n <= 1'b1;
        cycles(20);
      end
    end
    done("powerdown");
    bus(1, REG_CMD, OP_ALL_FLOAT);
    bus(1, REG_CMD, OP_FLOAT_RELEASE);
    bus(0, REG_STATUS, 0);
    chk(rd, exp_st(3'h0, 2'h0, 1'b1));
    done("release");
    // rise accelerator only on bits going high
    bus(1, REG_PORT_ONE, 32'h00);
    bus(1, REG_PORT_ONE, 32'h0f);
    i = 0;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      i = i | p1_acc;
    end
    chk(i[7:4], 4'h0);
    chk(i[3:0], 4'hf);
    chk(p1_out, 8'h0f);
    done("accel");
    // step/hold pin: hold at cycle end, and after oscillator stop
    ss_n <= 1'b0;
    cycles(20);
    chk(cpu_clk_en, 1'b0);
    bus(0, REG_STATUS, 0);
    chk(rd, exp_st(3'h4, 2'h0, 1'b1));
    ss_n <= 1'b1;
    cycles(2);
    chk(cpu_clk_en, 1'b1);
    bus(1, REG_CMD, OP_OSC_STOP);
    ss_n <= 1'b0;
    int_n <= 1'b0;
    cycles(3);
    bus(0, REG_STATUS, 0);
    chk(rd, exp_st(3'h4, 2'h0, 1'b0));
    chk({cpu_clk_en, pu_en}, 2'b01);
    int_n <= 1'b1;
    ss_n <= 1'b1;
    cycles(2);
    chk(cpu_clk_en, 1'b1);
    done("step");
    // interrupt enable gating
    int_n <= 1'b0;
    cycles(3);
    chk(int_req, 1'b0);
    int_n <= 1'b1;
    bus(1, REG_CTRL, 32'h1);
    int_n <= 1'b0;
    cycles(3);
    chk(int_req, 1'b1);
    int_n <= 1'b1;
    cycles(40);
    done("interrupt");
    // hardware standby, left by reset
    standby_pin <= 1'b0;
    cycles(3);
    bus(0, REG_STATUS, 0);
    chk(rd, exp_st(3'h3, 2'h0, 1'b1));
    chk({osc_run, p1_oe_n, pd_en, pu_en}, {1'b0, 8'hff, 2'b10});
    standby_pin <= 1'b1;
    rst_n <= 1'b0;
    cycles(30);
    rst_n <= 1'b1;
    bus(0, REG_STATUS, 0);
    chk(rd, exp_st(3'h0, 2'h0, 1'b1));
    bus(0, REG_CTRL, 0);
    chk(rd, 32'h0);
    done("standby");
    wrap_up();
  end
endmodule
`default_nettype wire
